// file: design/eam_defines.svh
`ifndef EAM_DEFINES_SVH
`define EAM_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define EAM_IDX_ACC_MODE 8'h0f
`define EAM_IDX_GAIN 8'h1b
`define EAM_IDX_ZX_EN 8'h2b
`define EAM_IDX_IRQ_STAT 8'h40
`define EAM_IDX_IRQ_MASK 8'h41

// Accumulation mode fields.
`define EAM_ACC_TAMPER_BIT 7
`define EAM_ACC_FAULT_SEL_BIT 6
`define EAM_ACC_RSIGN_SEL_BIT 5
`define EAM_ACC_ASIGN_SEL_BIT 4
`define EAM_ACC_R_ABS_BIT 3
`define EAM_ACC_R_SBA_BIT 2
`define EAM_ACC_A_POS_BIT 1
`define EAM_ACC_A_ABS_BIT 0
`define EAM_ACC_WR_MASK 8'h7f

// Gain fields.
`define EAM_GAIN_V_HI 7
`define EAM_GAIN_V_LO 5
`define EAM_GAIN_SRC_BIT 3
`define EAM_GAIN_I_HI 2
`define EAM_GAIN_I_LO 0
`define EAM_GAIN_WR_MASK 8'hef

// Zero-crossing output enables.
`define EAM_ZX_FIRST_BIT 1
`define EAM_ZX_SECOND_BIT 0
`define EAM_ZX_WR_MASK 8'h03

// Interrupt status and mask fields.
`define EAM_IRQ_ASIGN_BIT 0
`define EAM_IRQ_RSIGN_BIT 1
`define EAM_IRQ_FAULT_BIT 2
`define EAM_IRQ_WR_MASK 8'h07

// Reset values.
`define EAM_RST_REG8 8'h00
`define EAM_RST_WORD 32'h0000_0000

`endif

// file: design/eam_pkg.sv
package eam_pkg;

  typedef logic signed [23:0] eam_power_t;
  typedef logic signed [15:0] eam_sample_t;
  typedef logic signed [19:0] eam_scaled_t;
  typedef logic [7:0] eam_reg8_t;

endpackage : eam_pkg

// file: design/eam_sign_det.sv
`timescale 1ns/1ps
`default_nettype none

module eam_sign_det
  import eam_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Observed state.
  input wire logic valid_i,
  input wire logic neg_i,
  input wire logic edge_sel_i,
  // Event.
  output logic event_o
);

  logic seen_reg;
  logic neg_reg;

  // The first observation only primes the tracker, so reset never fakes a change.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      seen_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else if (valid_i) begin
      seen_reg <= 1'b1;
      neg_reg <= neg_i;
    end
  end

  // Select 0 fires on the change into the set state, select 1 on the change out of it.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      event_o <= 1'b0;
    end else begin
      event_o <= valid_i && seen_reg && (neg_i != neg_reg) && (neg_i != edge_sel_i);
    end
  end

endmodule : eam_sign_det

`default_nettype wire

// file: design/eam_power_cond.sv
`timescale 1ns/1ps
`default_nettype none

module eam_power_cond
  import eam_pkg::*;
(
  // Mode controls.
  input wire logic act_abs_i,
  input wire logic act_pos_only_i,
  input wire logic react_abs_i,
  input wire logic react_signed_i,
  // Power in.
  input wire eam_power_t act_i,
  input wire eam_power_t react_i,
  // Conditioned power out.
  output eam_power_t act_o,
  output eam_power_t react_o
);

  // Absolute mode takes precedence over positive-only when both are set.
  always_comb begin
    if (act_abs_i && act_i[23]) begin
      act_o = -act_i;
    end else if (!act_abs_i && act_pos_only_i && act_i[23]) begin
      act_o = '0;
    end else begin
      act_o = act_i;
    end
  end

  // Absolute mode takes precedence over sign-by-active when both are set.
  always_comb begin
    if (react_abs_i && react_i[23]) begin
      react_o = -react_i;
    end else if (!react_abs_i && react_signed_i && act_i[23]) begin
      react_o = -react_i;
    end else begin
      react_o = react_i;
    end
  end

endmodule : eam_power_cond

`default_nettype wire

// file: design/eam_config_top.sv
// Functional notes
// - Bit 7 of accumulation mode reads which current input feeds antitamper metering.
// - Fault select 0 interrupts on entering fault, 1 on returning normal.
// - Reactive edge select 0 interrupts on positive-to-negative, 1 on reverse.
// - Active edge select 0 interrupts on positive-to-negative, 1 on reverse.
// - Reactive absolute bit accumulates magnitude of reactive power and its pulses.
// - Signed-by-active bit flips reactive power sign while active power is negative.
// - Positive-only bit accumulates only positive active power.
// - Active absolute bit accumulates magnitude of active power.
// - Voltage gain code 0 to 4 selects gains 1,2,4,8,16.
// - Current gain code 0 to 4 selects gains 1,2,4,8,16.
// - Sign source bit picks filtered power (0) or each pulse (1).
// - First zero-cross enable drives the indication onto the first port pin.
// - Second zero-cross enable drives the indication onto the second port pin.
// - Active sign status flag sets on the selected active sign change.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "eam_defines.svh"

module eam_config_top
  import eam_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Metering core status.
  input wire logic tamper_channel_b_i,
  input wire logic fault_mode_i,
  input wire logic zero_cross_i,
  // Filtered power samples.
  input wire logic act_valid_i,
  input wire eam_power_t act_power_i,
  input wire logic react_valid_i,
  input wire eam_power_t react_power_i,
  // Energy pulse events with their sign.
  input wire logic act_pulse_i,
  input wire logic act_pulse_neg_i,
  input wire logic react_pulse_i,
  input wire logic react_pulse_neg_i,
  // Channel samples.
  input wire logic samp_valid_i,
  input wire eam_sample_t voltage_i,
  input wire eam_sample_t current_i,
  // Accumulation feed.
  output logic act_accum_valid_o,
  output eam_power_t act_accum_o,
  output logic react_accum_valid_o,
  output eam_power_t react_accum_o,
  // Scaled channels.
  output logic scaled_valid_o,
  output eam_scaled_t voltage_scaled_o,
  output eam_scaled_t current_scaled_o,
  // Port pins.
  output logic zero_cross_first_pin_o,
  output logic zero_cross_second_pin_o,
  // Interrupt.
  output logic irq_o
);

  eam_reg8_t acc_mode_reg;
  eam_reg8_t gain_reg;
  eam_reg8_t zx_en_reg;
  eam_reg8_t irq_stat_reg;
  eam_reg8_t irq_stat_next;
  eam_reg8_t irq_mask_reg;
  logic tamper_reg;
  logic setup;
  logic wr_en;
  logic [7:0] idx;
  logic addr_ok;
  logic hit_acc;
  logic hit_gain;
  logic hit_zx;
  logic hit_stat;
  logic hit_mask;
  eam_reg8_t wbyte;
  eam_reg8_t rd_mux;
  logic src_pulse;
  logic asign_valid;
  logic asign_neg;
  logic rsign_valid;
  logic rsign_neg;
  logic asign_evt;
  logic rsign_evt;
  logic fault_evt;
  eam_power_t act_cond;
  eam_power_t react_cond;
  logic [2:0] v_code;
  logic [2:0] i_code;

  // Codes above four are undefined for software; they fall back to unity gain.
  function automatic eam_scaled_t eam_apply_gain(input eam_sample_t s, input logic [2:0] code);
    eam_scaled_t e;
    e = {{4{s[15]}}, s};
    case (code)
      3'h1: eam_apply_gain = e <<< 1;
      3'h2: eam_apply_gain = e <<< 2;
      3'h3: eam_apply_gain = e <<< 3;
      3'h4: eam_apply_gain = e <<< 4;
      default: eam_apply_gain = e;
    endcase
  endfunction : eam_apply_gain

  // Bus decode.
  assign setup = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
  assign idx = paddr_i[9:2];
  assign addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i[31:10] == 22'h0);
  assign hit_acc = addr_ok && (idx == `EAM_IDX_ACC_MODE);
  assign hit_gain = addr_ok && (idx == `EAM_IDX_GAIN);
  assign hit_zx = addr_ok && (idx == `EAM_IDX_ZX_EN);
  assign hit_stat = addr_ok && (idx == `EAM_IDX_IRQ_STAT);
  assign hit_mask = addr_ok && (idx == `EAM_IDX_IRQ_MASK);
  assign wbyte = pwdata_i[7:0];
  assign v_code = gain_reg[`EAM_GAIN_V_HI:`EAM_GAIN_V_LO];
  assign i_code = gain_reg[`EAM_GAIN_I_HI:`EAM_GAIN_I_LO];

  always_comb begin
    rd_mux = `EAM_RST_REG8;
    if (hit_acc) begin
      rd_mux = {tamper_reg, acc_mode_reg[6:0]};
    end else if (hit_gain) begin
      rd_mux = gain_reg;
    end else if (hit_zx) begin
      rd_mux = zx_en_reg;
    end else if (hit_stat) begin
      rd_mux = irq_stat_reg;
    end else if (hit_mask) begin
      rd_mux = irq_mask_reg;
    end
  end

  // Every transfer completes in its first access cycle; pready is a flop for clean timing.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= `EAM_RST_WORD;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup && !(hit_acc || hit_gain || hit_zx || hit_stat || hit_mask);
      if (setup && !pwrite_i) begin
        prdata_o <= {24'h0, rd_mux};
      end
    end
  end

  // The tamper indicator follows the metering core and ignores writes.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tamper_reg <= 1'b0;
    end else begin
      tamper_reg <= tamper_channel_b_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      acc_mode_reg <= `EAM_RST_REG8;
    end else if (wr_en && hit_acc) begin
      acc_mode_reg <= wbyte & `EAM_ACC_WR_MASK;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      gain_reg <= `EAM_RST_REG8;
    end else if (wr_en && hit_gain) begin
      gain_reg <= wbyte & `EAM_GAIN_WR_MASK;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      zx_en_reg <= `EAM_RST_REG8;
    end else if (wr_en && hit_zx) begin
      zx_en_reg <= wbyte & `EAM_ZX_WR_MASK;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_mask_reg <= `EAM_RST_REG8;
    end else if (wr_en && hit_mask) begin
      irq_mask_reg <= wbyte & `EAM_IRQ_WR_MASK;
    end
  end

  // Sign detection source.
  assign src_pulse = gain_reg[`EAM_GAIN_SRC_BIT];
  assign asign_valid = src_pulse ? act_pulse_i : act_valid_i;
  assign asign_neg = src_pulse ? act_pulse_neg_i : act_power_i[23];
  assign rsign_valid = src_pulse ? react_pulse_i : react_valid_i;
  assign rsign_neg = src_pulse ? react_pulse_neg_i : react_power_i[23];

  eam_sign_det u_act_sign (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .valid_i(asign_valid),
    .neg_i(asign_neg),
    .edge_sel_i(acc_mode_reg[`EAM_ACC_ASIGN_SEL_BIT]),
    .event_o(asign_evt)
  );

  eam_sign_det u_react_sign (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .valid_i(rsign_valid),
    .neg_i(rsign_neg),
    .edge_sel_i(acc_mode_reg[`EAM_ACC_RSIGN_SEL_BIT]),
    .event_o(rsign_evt)
  );

  // Fault mode is the set state, so select 0 catches the entry and 1 the return.
  eam_sign_det u_fault (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .valid_i(1'b1),
    .neg_i(fault_mode_i),
    .edge_sel_i(acc_mode_reg[`EAM_ACC_FAULT_SEL_BIT]),
    .event_o(fault_evt)
  );

  // A new event wins over a write-one-to-clear in the same cycle.
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_en && hit_stat) begin
      irq_stat_next = irq_stat_reg & ~wbyte;
    end
    irq_stat_next[`EAM_IRQ_ASIGN_BIT] = irq_stat_next[`EAM_IRQ_ASIGN_BIT] | asign_evt;
    irq_stat_next[`EAM_IRQ_RSIGN_BIT] = irq_stat_next[`EAM_IRQ_RSIGN_BIT] | rsign_evt;
    irq_stat_next[`EAM_IRQ_FAULT_BIT] = irq_stat_next[`EAM_IRQ_FAULT_BIT] | fault_evt;
    irq_stat_next = irq_stat_next & `EAM_IRQ_WR_MASK;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_stat_reg <= `EAM_RST_REG8;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  // Built from next state so the line rises with the flag, not a cycle later.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_next & irq_mask_reg);
    end
  end

  eam_power_cond u_cond (
    .act_abs_i(acc_mode_reg[`EAM_ACC_A_ABS_BIT]),
    .act_pos_only_i(acc_mode_reg[`EAM_ACC_A_POS_BIT]),
    .react_abs_i(acc_mode_reg[`EAM_ACC_R_ABS_BIT]),
    .react_signed_i(acc_mode_reg[`EAM_ACC_R_SBA_BIT]),
    .act_i(act_power_i),
    .react_i(react_power_i),
    .act_o(act_cond),
    .react_o(react_cond)
  );

  // Energy registers and pulse generators both consume this one feed.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      act_accum_valid_o <= 1'b0;
      act_accum_o <= '0;
    end else begin
      act_accum_valid_o <= act_valid_i;
      if (act_valid_i) begin
        act_accum_o <= act_cond;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      react_accum_valid_o <= 1'b0;
      react_accum_o <= '0;
    end else begin
      react_accum_valid_o <= react_valid_i;
      if (react_valid_i) begin
        react_accum_o <= react_cond;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      scaled_valid_o <= 1'b0;
      voltage_scaled_o <= '0;
      current_scaled_o <= '0;
    end else begin
      scaled_valid_o <= samp_valid_i;
      if (samp_valid_i) begin
        voltage_scaled_o <= eam_apply_gain(voltage_i, v_code);
        current_scaled_o <= eam_apply_gain(current_i, i_code);
      end
    end
  end

  // A disabled pin rests low.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      zero_cross_first_pin_o <= 1'b0;
      zero_cross_second_pin_o <= 1'b0;
    end else begin
      zero_cross_first_pin_o <= zero_cross_i && zx_en_reg[`EAM_ZX_FIRST_BIT];
      zero_cross_second_pin_o <= zero_cross_i && zx_en_reg[`EAM_ZX_SECOND_BIT];
    end
  end

endmodule : eam_config_top

`default_nettype wire

// file: sim/eam_config_checker.sv
`timescale 1ns/1ps
`default_nettype none

module eam_config_checker
  import eam_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // APB.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Status and datapath.
  input wire logic tamper_channel_b_i,
  input wire logic act_valid_i,
  input wire logic act_accum_valid_o,
  input wire logic react_valid_i,
  input wire logic react_accum_valid_o,
  input wire logic samp_valid_i,
  input wire logic scaled_valid_o,
  input wire logic zero_cross_i,
  input wire logic zero_cross_first_pin_o,
  input wire logic zero_cross_second_pin_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  chk_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready missing after setup");
  chk_ready_once: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  // A refused write leaves the last read data standing, so only reads must return zero.
  chk_bad_addr: assert property (
    psel_i && !penable_i && paddr_i[1:0] != 2'b00
    |=> pslverr_o && ($past(pwrite_i) || prdata_o == 32'h0))
    else $error("misaligned access not refused");
  // The tamper bit is registered once, so only a steady input gives a fixed answer.
  chk_tamper_read: assert property (
    psel_i && !penable_i && !pwrite_i && paddr_i == 32'h3c && $stable(tamper_channel_b_i)
    |=> prdata_o[7] == $past(tamper_channel_b_i))
    else $error("tamper bit mismatch");
  chk_act_latency: assert property (act_valid_i |=> act_accum_valid_o)
    else $error("active output late");
  chk_react_latency: assert property (react_valid_i |=> react_accum_valid_o)
    else $error("reactive output late");
  chk_scaled_latency: assert property (samp_valid_i |=> scaled_valid_o)
    else $error("scaled output late");
  chk_zx_first: assert property (!zero_cross_i |=> !zero_cross_first_pin_o)
    else $error("first pin high without crossing");
  chk_zx_second: assert property (!zero_cross_i |=> !zero_cross_second_pin_o)
    else $error("second pin high without crossing");
  chk_rdata_high: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule : eam_config_checker

bind eam_config_top eam_config_checker u_chk (
  .clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o,
  .pready_o, .pslverr_o, .tamper_channel_b_i, .act_valid_i, .act_accum_valid_o,
  .react_valid_i, .react_accum_valid_o, .samp_valid_i, .scaled_valid_o,
  .zero_cross_i, .zero_cross_first_pin_o, .zero_cross_second_pin_o
);

`default_nettype wire

// file: sim/tb_energy_accum_mode_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "eam_defines.svh"

module tb_energy_accum_mode_config
  import eam_pkg::*;
;
  localparam logic [31:0] A_ACC = {22'h0, `EAM_IDX_ACC_MODE, 2'b00};
  localparam logic [31:0] A_GAIN = {22'h0, `EAM_IDX_GAIN, 2'b00};
  localparam logic [31:0] A_ZX = {22'h0, `EAM_IDX_ZX_EN, 2'b00};
  localparam logic [31:0] A_STAT = {22'h0, `EAM_IDX_IRQ_STAT, 2'b00};
  localparam logic [31:0] A_MASK = {22'h0, `EAM_IDX_IRQ_MASK, 2'b00};
  localparam eam_power_t POS = 24'h000001;
  localparam eam_power_t NEG = 24'hffffff;
  logic clk_sys_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic tamper_channel_b_i = 0, fault_mode_i = 0, zero_cross_i = 0, samp_valid_i = 0;
  logic act_valid_i = 0, react_valid_i = 0, act_pulse_i = 0, react_pulse_i = 0;
  logic act_pulse_neg_i = 0, react_pulse_neg_i = 0;
  logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o, r, e;
  logic [3:0] pstrb_i = 4'hf;
  eam_power_t act_power_i = 0, react_power_i = 0, act_accum_o, react_accum_o;
  eam_sample_t voltage_i = 16'h0003, current_i = 16'hffff;
  eam_scaled_t voltage_scaled_o, current_scaled_o;
  logic pready_o, pslverr_o, act_accum_valid_o, react_accum_valid_o, scaled_valid_o, irq_o;
  logic zero_cross_first_pin_o, zero_cross_second_pin_o;
  logic [7:0] msk = 0;
  int mismatches = 0, checked = 0;
  logic [31:0] aa [5] = '{A_ACC, A_GAIN, A_ZX, A_STAT, A_MASK};
  logic [31:0] wx [5] = '{32'h7f, 32'hef, 32'h03, 32'h00, 32'h07};

  initial forever #5 clk_sys_i = ~clk_sys_i;

  eam_config_top dut (
    .clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .tamper_channel_b_i, .fault_mode_i,
    .zero_cross_i, .act_valid_i, .act_power_i, .react_valid_i, .react_power_i,
    .act_pulse_i, .act_pulse_neg_i, .react_pulse_i, .react_pulse_neg_i, .samp_valid_i,
    .voltage_i, .current_i, .act_accum_valid_o, .act_accum_o, .react_accum_valid_o,
    .react_accum_o, .scaled_valid_o, .voltage_scaled_o, .current_scaled_o,
    .zero_cross_first_pin_o, .zero_cross_second_pin_o, .irq_o
  );

  task automatic close_out;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  // Outputs read right after an edge still hold the values sampled at that edge.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = {31'h0, pslverr_o};
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic feed(input eam_power_t a, input eam_power_t rp, input logic [4:0] s);
    @(posedge clk_sys_i);
    {act_valid_i, react_valid_i, act_pulse_i, react_pulse_i} <= 4'hf;
    act_power_i <= a;
    react_power_i <= rp;
    {fault_mode_i, react_pulse_neg_i, act_pulse_neg_i} <= s[4:2];
    @(posedge clk_sys_i);
    {act_valid_i, react_valid_i, act_pulse_i, react_pulse_i} <= 4'h0;
    @(posedge clk_sys_i);
  endtask : feed

  task automatic acc(input logic [7:0] m, input eam_power_t a, input eam_power_t rp,
                     input eam_power_t ea, input eam_power_t er);
    apb(1'b1, A_ACC, {24'h0, m});
    feed(a, rp, 5'h0);
    feed(a, rp, 5'h0);
    chk({8'h0, act_accum_o}, {8'h0, ea});
    chk({8'h0, react_accum_o}, {8'h0, er});
  endtask : acc

  // Status is cleared between the two samples so only the second change counts.
  task automatic sgn(input logic [7:0] m, input logic [7:0] g, input logic [4:0] s1,
                     input logic [4:0] s2, input logic [7:0] x);
    apb(1'b1, A_ACC, {24'h0, m});
    apb(1'b1, A_GAIN, {24'h0, g});
    feed(s1[0] ? NEG : POS, s1[1] ? NEG : POS, s1);
    apb(1'b1, A_STAT, 32'h7);
    feed(s2[0] ? NEG : POS, s2[1] ? NEG : POS, s2);
    apb(1'b0, A_STAT, 32'h0);
    chk(r, {24'h0, x});
    chk({31'h0, irq_o}, {31'h0, |(x & msk)});
  endtask : sgn

  initial begin
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    foreach (aa[i]) begin
      apb(1'b0, aa[i], 32'h0);
      chk(r, 32'h0);
      chk(e, 32'h0);
      apb(1'b1, aa[i], 32'hff);
      apb(1'b0, aa[i], 32'h0);
      chk(r, wx[i]);
      apb(1'b1, aa[i], 32'h0);
    end
    apb(1'b1, 32'h40, 32'hff);
    chk(e, 32'h1);
    apb(1'b0, 32'h3d, 32'h0);
    chk(r, 32'h0);
    chk(e, 32'h1);
    tamper_channel_b_i <= 1'b1;
    apb(1'b0, A_ACC, 32'h0);
    chk(r, 32'h80);
    tamper_channel_b_i <= 1'b0;
    pstrb_i <= 4'h0;
    apb(1'b1, A_ZX, 32'h3);
    pstrb_i <= 4'hf;
    apb(1'b0, A_ZX, 32'h0);
    chk(r, 32'h0);
    $display("register test done");
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, A_GAIN, 32'(c * 33));
      @(posedge clk_sys_i);
      samp_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      samp_valid_i <= 1'b0;
      @(posedge clk_sys_i);
      chk({12'h0, voltage_scaled_o}, {12'h0, 20'h00003 << c});
      chk({12'h0, current_scaled_o}, {12'h0, 20'hfffff << c});
    end
    $display("gain test done");
    acc(8'h00, 24'hfffffb, 24'hfffff9, 24'hfffffb, 24'hfffff9);
    acc(8'h01, 24'hfffffb, 24'h000007, 24'h000005, 24'h000007);
    acc(8'h02, 24'hfffffb, 24'h000007, 24'h000000, 24'h000007);
    acc(8'h02, 24'h000005, 24'h000007, 24'h000005, 24'h000007);
    acc(8'h08, 24'h000005, 24'hfffff9, 24'h000005, 24'h000007);
    acc(8'h04, 24'hfffffb, 24'h000007, 24'hfffffb, 24'hfffff9);
    acc(8'h04, 24'h000005, 24'h000007, 24'h000005, 24'h000007);
    $display("accumulation test done");
    msk = 8'h07;
    apb(1'b1, A_MASK, 32'h7);
    sgn(8'h00, 8'h00, 5'h00, 5'h01, 8'h1);
    sgn(8'h10, 8'h00, 5'h00, 5'h01, 8'h0);
    sgn(8'h10, 8'h00, 5'h01, 5'h00, 8'h1);
    sgn(8'h00, 8'h00, 5'h00, 5'h02, 8'h2);
    sgn(8'h20, 8'h00, 5'h02, 5'h00, 8'h2);
    sgn(8'h00, 8'h08, 5'h00, 5'h04, 8'h1);
    sgn(8'h00, 8'h08, 5'h00, 5'h01, 8'h0);
    sgn(8'h00, 8'h00, 5'h00, 5'h10, 8'h4);
    sgn(8'h40, 8'h00, 5'h10, 5'h00, 8'h4);
    msk = 8'h00;
    apb(1'b1, A_MASK, 32'h0);
    sgn(8'h00, 8'h00, 5'h00, 5'h01, 8'h1);
    $display("event test done");
    zero_cross_i <= 1'b1;
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, A_ZX, 32'(v));
      repeat (2) @(posedge clk_sys_i);
      chk({30'h0, zero_cross_first_pin_o, zero_cross_second_pin_o}, 32'(v));
    end
    $display("zero crossing test done");
    close_out();
  end

  initial begin
    repeat (10000) @(posedge clk_sys_i);
    mismatches++;
    close_out();
  end
endmodule : tb_energy_accum_mode_config

`default_nettype wire
